// >>> rtl/fet_erase_trigger.sv
// Erase command register logic for the program flash
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// R1 - Writing 0x55 to the erase command register starts one page erase.
// R2 - Software writes the target page number into bits 7:1 beforehand.
// R3 - Writing 0xAA to the erase command register starts a mass erase.
// R4 - Mass erase needs the arm bit set and the emulator port enabled.
// R5 - Any other value written is ignored and starts nothing.
// R6 - Arm bit is write-only bit 1, clear after reset, set to arm.
// R7 - Arm bit is cleared after each mass erase attempt.
module fet_erase_trigger
	import fet_pkg::*;
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	// Special-function register write port
	input wire logic i_sfr_we,
	input wire logic [7:0] i_sfr_addr,
	input wire logic [7:0] i_sfr_wdata,
	// Emulator port status
	input wire logic i_emulator_port_en,
	// Flash controller requests
	output logic o_page_erase_start,
	output logic o_mass_erase_start,
	output logic [6:0] o_flash_page_select,
	output logic o_mass_erase_arm
);

	// Write taken on the rising edge with the strobe high
	// Start strobes follow on that edge and last one clock
	// Page select holds until rewritten; arm holds until rewritten or a mass erase attempt
	// All three registers are write-only, no read path
	// Bit 0 of page select and other arm bits ignored

	// Everything the block remembers between cycles
	typedef struct packed {
		logic page_start;
		logic mass_start;
		logic [6:0] page;
		logic arm;
	} fet_state_t;

	// Register addressed by this cycle's write
	typedef enum logic [3:0] {
		FET_SEL_NONE = 4'h1,
		FET_SEL_PAGE = 4'h2,
		FET_SEL_ARM = 4'h4,
		FET_SEL_CMD = 4'h8
	} fet_reg_sel_t;

	// Meaning of the data written to the erase command register
	typedef enum logic [2:0] {
		FET_CMD_NONE = 3'h1,
		FET_CMD_PAGE = 3'h2,
		FET_CMD_MASS = 3'h4
	} fet_cmd_kind_t;

	// State and its next value
	fet_state_t st;
	fet_state_t next_st;

	// Decoded write
	fet_reg_sel_t reg_sel;
	fet_cmd_kind_t cmd_kind;

	// Fields lifted from the write data
	logic [6:0] page_field;
	logic arm_field;

	// Mass erase may start this cycle
	logic mass_permitted;

	// Only the two exact patterns count as commands
	function automatic fet_cmd_kind_t decode_cmd(input logic [7:0] data);
		fet_cmd_kind_t kind;
		kind = FET_CMD_NONE;
		case (data)
			FET_PAT_PAGE:
			begin
				kind = FET_CMD_PAGE; // R1
			end
			FET_PAT_MASS:
			begin
				kind = FET_CMD_MASS; // R3
			end
			default:
			begin
				kind = FET_CMD_NONE; // R5
			end
		endcase
		return kind;
	endfunction

	// Write strobe steered to one of the three registers
	always_comb
	begin
		reg_sel = FET_SEL_NONE;
		if (i_sfr_we)
		begin
			case (i_sfr_addr)
				FET_PAGE_SEL_ADDR:
				begin
					reg_sel = FET_SEL_PAGE;
				end
				FET_ARM_ADDR:
				begin
					reg_sel = FET_SEL_ARM;
				end
				FET_ERASE_CMD_ADDR:
				begin
					reg_sel = FET_SEL_CMD;
				end
				default:
				begin
					// Other addresses belong to other blocks
					reg_sel = FET_SEL_NONE;
				end
			endcase
		end
	end

	// Page number sits one bit up in its register; bit 0 is dropped
	for (genvar gi = 0; gi <= FET_PAGE_MSB - FET_PAGE_LSB; gi++)
	begin : g_page_bit
		assign page_field[gi] = i_sfr_wdata[gi + FET_PAGE_LSB]; // R2
	end

	// Only one bit of the arm register is used
	assign arm_field = i_sfr_wdata[FET_ARM_BIT]; // R6

	// Pattern decode only for writes to the command register
	always_comb
	begin
		cmd_kind = FET_CMD_NONE;
		if (reg_sel == FET_SEL_CMD)
		begin
			cmd_kind = decode_cmd(i_sfr_wdata);
		end
	end

	// Arming must already sit in the register, not in this cycle's write
	// Emulator port is looked at only on the command write
	always_comb
	begin
		mass_permitted = 1'b0;
		if (st.arm && i_emulator_port_en)
		begin
			mass_permitted = 1'b1; // R4
		end
	end

	// Next register values
	always_comb
	begin
		next_st = st;
		// Start requests are single-cycle strobes
		next_st.page_start = 1'b0;
		next_st.mass_start = 1'b0;
		// Register writes
		case (reg_sel)
			FET_SEL_PAGE:
			begin
				next_st.page = page_field; // R2
			end
			FET_SEL_ARM:
			begin
				next_st.arm = arm_field; // R6
			end
			default:
			begin
				// Commands go through the pattern decode below
				next_st.page = st.page;
			end
		endcase
		// Arm write and command write never share a cycle
		case (cmd_kind)
			FET_CMD_PAGE:
			begin
				next_st.page_start = 1'b1; // R1
			end
			FET_CMD_MASS:
			begin
				next_st.mass_start = mass_permitted; // R3 R4
				// An attempt uses up the arming whether it started or not
				next_st.arm = 1'b0; // R7
			end
			default:
			begin
				// Ignored patterns change nothing
				next_st.page_start = 1'b0; // R5
			end
		endcase
	end

	// Reset clears the strobes, the page and the arming
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			st.page_start <= 1'b0;
			st.mass_start <= 1'b0;
			st.page <= FET_PAGE_RESET;
			// Mass erase starts disarmed
			st.arm <= 1'b0; // R6
		end
		else
		begin
			st <= next_st;
		end
	end

	// Outputs come straight from the state flip-flops
	assign o_page_erase_start = st.page_start;
	assign o_mass_erase_start = st.mass_start;
	assign o_flash_page_select = st.page;
	assign o_mass_erase_arm = st.arm;

endmodule
`default_nettype wire

// >>> rtl/fet_pkg.sv
// Package with constants for the flash erase trigger
package fet_pkg;
	localparam logic [7:0] FET_ERASE_CMD_ADDR = 8'h94;
	localparam logic [7:0] FET_PAGE_SEL_ADDR = 8'hb7;
	localparam logic [7:0] FET_ARM_ADDR = 8'hb2;
	localparam int FET_PAGE_MSB = 7;
	localparam int FET_PAGE_LSB = 1;
	localparam int FET_ARM_BIT = 1;
	localparam logic [7:0] FET_PAT_PAGE = 8'h55;
	localparam logic [7:0] FET_PAT_MASS = 8'haa;
	localparam logic [7:0] FET_CMD_RESET = 8'h00;
	localparam logic [6:0] FET_PAGE_RESET = 7'h00;
endpackage

// >>> sim/fet_erase_trigger_bench.sv
// Erase trigger bench
`timescale 1ns/100ps
`default_nettype none
module fet_erase_trigger_bench;
	logic c=0,r=0,we=0,e=0;
	logic [7:0] ad=0,d=0,x;
	wire p,m,ar;
	wire [6:0] pg;
	int miscompares=0,n_tests=0,s;
	fet_erase_trigger u_dut(.i_core_clk(c),.i_rst_b(r),.i_sfr_we(we),.i_sfr_addr(ad),
		.i_sfr_wdata(d),.i_emulator_port_en(e),.o_page_erase_start(p),
		.o_mass_erase_start(m),.o_flash_page_select(pg),.o_mass_erase_arm(ar));
	task wr(input logic [7:0] y,z); @(posedge c) {we,ad,d}<={1'b1,y,z}; @(posedge c) we<=0; #1; endtask
	task ck(input logic [7:0] y,z); n_tests++;
		if(y!==z) begin miscompares++; $display("ERROR %0t bad",$time); end endtask
	task close_out; $display("%0d %0d",n_tests,miscompares);
		if(miscompares==0&&n_tests>0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish; endtask
	initial forever #5 c=~c;
	initial
	begin
		s=$urandom(32'hbb0d);
		repeat(20) @(posedge c);
		ck(ar,0);
		r<=1;
		repeat(99)
		begin
			s=$urandom;
			x=s[8]?8'haa:s[10]?8'h55:s[23:16];
			@(posedge c) e<=s[9];
			wr(8'hb2,s[7:0]);
			wr(8'hb7,s[15:8]);
			ck(pg,s[15:9]);
			wr(8'h94,x);
			ck(p,x==8'h55);
			ck(m,x==8'haa&&s[1]&&s[9]);
			ck(ar,s[1]&&x!=8'haa);
		end
		// Corners: page bit 0 dropped, one arming per attempt, reset disarms
		@(posedge c) e<=1'b1;
		wr(8'hb7,8'hff);
		ck(pg,8'h7f);
		wr(8'hb2,8'h02);
		ck(ar,8'h01);
		wr(8'h94,8'haa);
		ck(m,8'h01);
		ck(ar,8'h00);
		wr(8'h94,8'haa);
		ck(m,8'h00);
		wr(8'hb2,8'h02);
		@(posedge c) r<=1'b0;
		@(posedge c) r<=1'b1;
		#1;
		ck(ar,8'h00);
		ck(pg,8'h00);
		wr(8'h94,8'haa);
		ck(m,8'h00);
		close_out;
	end
endmodule
`default_nettype wire

// >>> sim/fet_erase_trigger_properties.sv
// Erase trigger checker
`timescale 1ns/100ps
`default_nettype none
module fet_chk(input wire logic i_core_clk,i_rst_b,i_sfr_we,i_emulator_port_en,
	input wire logic o_page_erase_start,o_mass_erase_start,o_mass_erase_arm,
	input wire logic [7:0] i_sfr_addr,i_sfr_wdata,
	input wire logic [6:0] o_flash_page_select);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	wire w=i_sfr_we&&i_sfr_addr==8'h94,b=i_sfr_we&&i_sfr_addr==8'hb2;
	wire p=w&&i_sfr_wdata==8'h55,a=w&&i_sfr_wdata==8'haa,k=o_mass_erase_arm&&i_emulator_port_en;
	wire q=i_sfr_we&&i_sfr_addr==8'hb7;
	pg_start_a: assert property(o_page_erase_start==$past(p&&i_rst_b)) else $error("pg");
	ms_start_a: assert property(o_mass_erase_start==$past(a&&k&&i_rst_b)) else $error("ms");
	arm_set_a: assert property(b|=>o_mass_erase_arm==$past(i_sfr_wdata[1])) else $error("as");
	arm_clr_a: assert property(a|=>!o_mass_erase_arm) else $error("ac");
	page_load_a: assert property(q|=>o_flash_page_select==$past(i_sfr_wdata[7:1])) else $error("pl");
	page_hold_a: assert property(!q|=>$stable(o_flash_page_select)) else $error("ph");
	arm_hold_a: assert property(!(a||b)|=>$stable(o_mass_erase_arm)) else $error("ah");
	cover property(o_page_erase_start);
	cover property(o_mass_erase_start);
	cover property(a&&!k);
endmodule
bind fet_erase_trigger fet_chk u_chk(.*);
`default_nettype wire
